// *** src/fms_top.sv ***
// Modbus slave request handler for a fan-array controller.
// Assumes a frame decoder loads requests over APB and a fan-bus engine
// serves the fan port with a one-cycle done pulse.
`timescale 1ns/1ns
module fms_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    output fms_pkg::fms_fan_req_s fan_req,
    input  wire logic        fan_done,
    input  wire logic [15:0] fan_rdata,
    output logic             rsp_valid
);
    localparam int SYS_N = 6;

    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  acc_addr;
    logic [31:0] acc_wdata;
    logic [31:0] rd_value;
    logic        rd_err;
    logic        tmo;
    logic        tmr_start;
    logic        tmr_stop;
    logic [23:0] tmr_limit;

    fms_pkg::fms_req_s     req_reg, req_next;
    fms_pkg::fms_state_e   st_reg, st_next;
    fms_pkg::fms_mode_e    mode_reg, mode_next;
    fms_pkg::fms_fan_req_s fan_reg, fan_next;
    logic [7:0]  exc_reg, exc_next;
    logic [15:0] rdat_reg, rdat_next;
    logic        rspv_reg, rspv_next;
    logic        busy_reg, busy_next;
    logic [15:0] speed_sp_reg, speed_sp_next;
    logic [15:0] rpm_lim_reg, rpm_lim_next;
    logic [15:0] press_sp_reg, press_sp_next;
    logic [15:0] vol_sp_reg, vol_sp_next;
    logic [15:0] fan_speed_reg [fms_pkg::NUM_FANS];
    logic [15:0] fan_speed_next [fms_pkg::NUM_FANS];
    logic [15:0] sys_reg [SYS_N];
    logic [15:0] sys_next [SYS_N];
    logic [3:0]  fan_idx;

    fms_apb_slave u_apb (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .rd_value  (rd_value),
        .pready    (pready),
        .pslverr   (pslverr),
        .prdata    (prdata),
        .wr_stb    (wr_stb),
        .rd_stb    (rd_stb),
        .acc_addr  (acc_addr),
        .acc_wdata (acc_wdata),
        .rd_err    (rd_err)
    );

    fms_timer u_tmr (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (tmr_start),
        .stop    (tmr_stop),
        .limit   (tmr_limit),
        .expire  (tmo)
    );

    function automatic logic is_fan_addr(input logic [15:0] a);
        return a >= fms_pkg::FAN_WIN_FIRST && a <= fms_pkg::FAN_WIN_LAST;
    endfunction

    function automatic logic func_ok(input logic [7:0] f);
        return f == fms_pkg::FC_RD_HOLD || f == fms_pkg::FC_RD_INPUT ||
               f == fms_pkg::FC_WR_SINGLE || f == fms_pkg::FC_WR_MULTI;
    endfunction

    function automatic logic ctrl_mode(input fms_pkg::fms_mode_e m);
        return m == fms_pkg::FMS_MODE_MON_CTRL ||
               m == fms_pkg::FMS_MODE_CONSTANT ||
               m == fms_pkg::FMS_MODE_RELAY;
    endfunction

    function automatic logic is_write(input logic [7:0] f);
        return f == fms_pkg::FC_WR_SINGLE || f == fms_pkg::FC_WR_MULTI;
    endfunction

    // Register read mux and unmapped-address error
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_err   = 1'b0;
        unique case (acc_addr)
            fms_pkg::A_REQ_FUNC:   rd_value = {24'h00_0000, req_reg.func};
            fms_pkg::A_REQ_ADDR:   rd_value = {16'h0000, req_reg.addr};
            fms_pkg::A_REQ_COUNT:  rd_value = {16'h0000, req_reg.count};
            fms_pkg::A_REQ_DATA:   rd_value = {16'h0000, req_reg.data};
            fms_pkg::A_REQ_GO:     rd_value = 32'h0000_0000;
            fms_pkg::A_RSP_STATUS: rd_value = {22'h00_0000, busy_reg,
                                               rspv_reg, exc_reg};
            fms_pkg::A_RSP_DATA:   rd_value = {16'h0000, rdat_reg};
            fms_pkg::A_MODE:       rd_value = {29'h0000_0000, mode_reg};
            fms_pkg::A_SETPOINTS:  rd_value = {press_sp_reg, vol_sp_reg};
            fms_pkg::A_FAN_DATA:   rd_value = {speed_sp_reg, rpm_lim_reg};
            default: begin
                if (acc_addr >= fms_pkg::A_SYS_BASE &&
                    acc_addr < fms_pkg::A_SYS_BASE + 8'h18)
                    rd_value = {16'h0000,
                                sys_reg[3'((acc_addr - fms_pkg::A_SYS_BASE) >> 2)]};
                else
                    rd_err = 1'b1;
            end
        endcase
    end

    always_comb begin
        fan_idx = req_reg.addr[3:0];
    end

    // Request engine
    always_comb begin
        logic fan_cls;
        logic [15:0] lim;
        fan_cls        = is_fan_addr(req_reg.addr);
        lim            = 16'h0000;
        req_next       = req_reg;
        st_next        = st_reg;
        mode_next      = mode_reg;
        fan_next       = fan_reg;
        fan_next.valid = 1'b0;
        exc_next       = exc_reg;
        rdat_next      = rdat_reg;
        rspv_next      = 1'b0;
        busy_next      = busy_reg;
        speed_sp_next  = speed_sp_reg;
        rpm_lim_next   = rpm_lim_reg;
        press_sp_next  = press_sp_reg;
        vol_sp_next    = vol_sp_reg;
        fan_speed_next = fan_speed_reg;
        sys_next       = sys_reg;
        tmr_start      = 1'b0;
        tmr_stop       = 1'b0;
        tmr_limit      = 24'(fms_pkg::LOCAL_TMO_CYC);
        if (wr_stb && st_reg == fms_pkg::FMS_ST_IDLE) begin
            unique case (acc_addr)
                fms_pkg::A_REQ_FUNC:  req_next.func  = acc_wdata[7:0];
                fms_pkg::A_REQ_ADDR:  req_next.addr  = acc_wdata[15:0];
                fms_pkg::A_REQ_COUNT: req_next.count = acc_wdata[15:0];
                fms_pkg::A_REQ_DATA:  req_next.data  = acc_wdata[15:0];
                fms_pkg::A_MODE: mode_next = fms_pkg::fms_mode_e'(acc_wdata[2:0]);
                default: ;
            endcase
        end
        // Fan-side refresh of the per-fan speed mirrors is frozen in relay
        if (fan_done && !fan_reg.write && st_reg != fms_pkg::FMS_ST_FAN &&
            mode_reg != fms_pkg::FMS_MODE_RELAY) begin
            fan_speed_next[fan_idx] = fan_rdata;
        end
        unique case (st_reg)
            fms_pkg::FMS_ST_IDLE: begin
                if (wr_stb && acc_addr == fms_pkg::A_REQ_GO) begin
                    st_next   = fms_pkg::FMS_ST_CHECK;
                    busy_next = 1'b1;
                    tmr_start = 1'b1;
                    tmr_limit = is_fan_addr(req_reg.addr) ?
                                24'(fms_pkg::FAN_TMO_CYC) :
                                24'(fms_pkg::LOCAL_TMO_CYC);
                end
            end
            fms_pkg::FMS_ST_CHECK: begin
                lim = fan_cls ? 16'(fms_pkg::MAX_FAN_REGS) :
                                16'(fms_pkg::MAX_LOCAL_REGS);
                exc_next = fms_pkg::EX_NONE;
                st_next  = fms_pkg::FMS_ST_DONE;
                if (!func_ok(req_reg.func)) begin
                    exc_next = fms_pkg::EX_ILL_FUNC;
                end else if (req_reg.count == 16'h0000 ||
                             req_reg.count > lim) begin
                    exc_next = fms_pkg::EX_ILL_VALUE;
                end else if (fan_cls) begin
                    // Relayed access is never gated by mode
                    fan_next.valid     = 1'b1;
                    fan_next.write     = is_write(req_reg.func);
                    fan_next.addr      = req_reg.addr;
                    fan_next.data      = req_reg.data;
                    fan_next.broadcast = 1'b0;
                    st_next            = fms_pkg::FMS_ST_FAN;
                end else if (req_reg.func == fms_pkg::FC_RD_INPUT) begin
                    if (req_reg.addr >= fms_pkg::IR_SYS_FIRST &&
                        req_reg.addr <= fms_pkg::IR_SYS_LAST)
                        rdat_next = sys_reg[3'(req_reg.addr - 16'h0001)];
                    else
                        exc_next = fms_pkg::EX_ILL_ADDR;
                end else if (req_reg.func == fms_pkg::FC_RD_HOLD) begin
                    unique case (req_reg.addr)
                        fms_pkg::HR_ARRAY_SPEED: rdat_next = speed_sp_reg;
                        fms_pkg::HR_ARRAY_RPM:   rdat_next = rpm_lim_reg;
                        fms_pkg::HR_TGT_PRESS:   rdat_next = press_sp_reg;
                        fms_pkg::HR_TGT_VOLUME:  rdat_next = vol_sp_reg;
                        default: begin
                            if (req_reg.addr[15:4] == fms_pkg::HR_FAN_SPEED0[15:4])
                                rdat_next = fan_speed_reg[fan_idx];
                            else
                                exc_next = fms_pkg::EX_ILL_ADDR;
                        end
                    endcase
                end else if (!ctrl_mode(mode_reg)) begin
                    exc_next = fms_pkg::EX_ILL_VALUE;
                end else begin
                    unique case (req_reg.addr)
                        fms_pkg::HR_ARRAY_SPEED: begin
                            speed_sp_next      = req_reg.data;
                            fan_next.valid     = 1'b1;
                            fan_next.write     = 1'b1;
                            fan_next.addr      = req_reg.addr;
                            fan_next.data      = req_reg.data;
                            fan_next.broadcast = 1'b1;
                            st_next            = fms_pkg::FMS_ST_FAN;
                        end
                        fms_pkg::HR_ARRAY_RPM: begin
                            rpm_lim_next       = req_reg.data;
                            fan_next.valid     = 1'b1;
                            fan_next.write     = 1'b1;
                            fan_next.addr      = req_reg.addr;
                            fan_next.data      = req_reg.data;
                            fan_next.broadcast = 1'b1;
                            st_next            = fms_pkg::FMS_ST_FAN;
                        end
                        fms_pkg::HR_TGT_PRESS: press_sp_next = req_reg.data;
                        fms_pkg::HR_TGT_VOLUME: vol_sp_next = req_reg.data;
                        default: exc_next = fms_pkg::EX_ILL_ADDR;
                    endcase
                end
            end
            fms_pkg::FMS_ST_FAN: begin
                // The budget bounds a stuck fan bus
                if (fan_done) begin
                    if (!fan_reg.write)
                        rdat_next = fan_rdata;
                    st_next = fms_pkg::FMS_ST_DONE;
                end else if (tmo) begin
                    exc_next = fms_pkg::EX_TIMEOUT;
                    st_next  = fms_pkg::FMS_ST_DONE;
                end
            end
            fms_pkg::FMS_ST_DONE: begin
                rspv_next = 1'b1;
                busy_next = 1'b0;
                tmr_stop  = 1'b1;
                st_next   = fms_pkg::FMS_ST_IDLE;
            end
            default: st_next = fms_pkg::FMS_ST_IDLE;
        endcase
        // System totals are loaded by firmware over the bus, except in relay mode
        if (wr_stb && acc_addr >= fms_pkg::A_SYS_BASE &&
            acc_addr < fms_pkg::A_SYS_BASE + 8'h18 &&
            mode_reg != fms_pkg::FMS_MODE_RELAY)
            sys_next[3'((acc_addr - fms_pkg::A_SYS_BASE) >> 2)] = acc_wdata[15:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg      <= '0;
            st_reg       <= fms_pkg::FMS_ST_IDLE;
            mode_reg     <= fms_pkg::fms_mode_e'(fms_pkg::MODE_RESET_VAL);
            fan_reg      <= '0;
            exc_reg      <= fms_pkg::EX_NONE;
            rdat_reg     <= 16'h0000;
            rspv_reg     <= 1'b0;
            busy_reg     <= 1'b0;
            speed_sp_reg <= 16'h0000;
            rpm_lim_reg  <= 16'h0000;
            press_sp_reg <= 16'h0000;
            vol_sp_reg   <= 16'h0000;
            for (int i = 0; i < fms_pkg::NUM_FANS; i++)
                fan_speed_reg[i] <= 16'h0000;
            for (int i = 0; i < SYS_N; i++)
                sys_reg[i] <= 16'h0000;
        end else begin
            req_reg       <= req_next;
            st_reg        <= st_next;
            mode_reg      <= mode_next;
            fan_reg       <= fan_next;
            exc_reg       <= exc_next;
            rdat_reg      <= rdat_next;
            rspv_reg      <= rspv_next;
            busy_reg      <= busy_next;
            speed_sp_reg  <= speed_sp_next;
            rpm_lim_reg   <= rpm_lim_next;
            press_sp_reg  <= press_sp_next;
            vol_sp_reg    <= vol_sp_next;
            fan_speed_reg <= fan_speed_next;
            sys_reg       <= sys_next;
        end
    end

    assign fan_req   = fan_reg;
    assign rsp_valid = rspv_reg;
endmodule // fms_top

// *** src/fms_pkg.sv ***
// Package for the fan-array Modbus request handler: constants, types.
// Assumes a 10 MHz pclk; all users reference items as fms_pkg::name.
// Operation
// - Answer local registers within 500 ms, fan-relayed within 1 s.
// - Fan-relayed registers are served in every operating mode.
// - In relay mode the local per-fan registers stop being refreshed.
// - Only function codes 03, 04, 05 and 16 are accepted.
// - More than 13 consecutive local registers gets an exception.
// - More than 9 consecutive fan-relayed registers gets an exception.
// - Each fan has one local register mirroring its displayed speed.
// - System totals are input registers at addresses 1 to 6.
// - Writing array speed setpoint broadcasts it to all fans.
// - Writing array RPM limit broadcasts it to all fans.
// - Pressure and volume target writes replace the loop setpoints.
// - Array control writes act only in control, constant or relay mode.
package fms_pkg;
    localparam int CLK_HZ            = 10_000_000;
    localparam int LOCAL_TMO_MS      = 500;
    localparam int FAN_TMO_MS        = 1000;
    localparam int LOCAL_TMO_CYC     = CLK_HZ / 1000 * LOCAL_TMO_MS;
    localparam int FAN_TMO_CYC       = CLK_HZ / 1000 * FAN_TMO_MS;
    localparam int MAX_LOCAL_REGS    = 13;
    localparam int MAX_FAN_REGS      = 9;
    localparam int NUM_FANS          = 16;

    localparam logic [7:0] FC_RD_HOLD   = 8'h03;
    localparam logic [7:0] FC_RD_INPUT  = 8'h04;
    localparam logic [7:0] FC_WR_SINGLE = 8'h05;
    localparam logic [7:0] FC_WR_MULTI  = 8'h10;

    localparam logic [7:0] EX_NONE      = 8'h00;
    localparam logic [7:0] EX_ILL_FUNC  = 8'h01;
    localparam logic [7:0] EX_ILL_ADDR  = 8'h02;
    localparam logic [7:0] EX_ILL_VALUE = 8'h03;
    localparam logic [7:0] EX_TIMEOUT   = 8'h0B;

    // Modbus register address map
    localparam logic [15:0] IR_SYS_FIRST   = 16'h0001;
    localparam logic [15:0] IR_SYS_LAST    = 16'h0006;
    localparam logic [15:0] FAN_WIN_FIRST  = 16'h0200;
    localparam logic [15:0] FAN_WIN_LAST   = 16'hC9FF;
    localparam logic [15:0] HR_ARRAY_SPEED = 16'h0000;
    localparam logic [15:0] HR_ARRAY_RPM   = 16'h0001;
    localparam logic [15:0] HR_TGT_PRESS   = 16'h0002;
    localparam logic [15:0] HR_TGT_VOLUME  = 16'h0003;
    localparam logic [15:0] HR_FAN_SPEED0  = 16'h0100;

    // APB byte offsets
    localparam logic [7:0] A_REQ_FUNC   = 8'h00;
    localparam logic [7:0] A_REQ_ADDR   = 8'h04;
    localparam logic [7:0] A_REQ_COUNT  = 8'h08;
    localparam logic [7:0] A_REQ_DATA   = 8'h0C;
    localparam logic [7:0] A_REQ_GO     = 8'h10;
    localparam logic [7:0] A_RSP_STATUS = 8'h14;
    localparam logic [7:0] A_RSP_DATA   = 8'h18;
    localparam logic [7:0] A_MODE       = 8'h1C;
    localparam logic [7:0] A_FAN_DATA   = 8'h20;
    localparam logic [7:0] A_SYS_BASE   = 8'h40;
    localparam logic [7:0] A_SETPOINTS  = 8'h60;

    localparam logic [2:0] MODE_RESET_VAL = 3'h0;

    typedef enum logic [2:0] {
        FMS_MODE_MONITOR_ONLY = 3'h0,
        FMS_MODE_MON_CTRL     = 3'h1,
        FMS_MODE_CONSTANT     = 3'h2,
        FMS_MODE_RELAY        = 3'h3,
        FMS_MODE_STANDALONE   = 3'h4
    } fms_mode_e;

    typedef enum logic [3:0] {
        FMS_ST_IDLE  = 4'b0001,
        FMS_ST_CHECK = 4'b0010,
        FMS_ST_FAN   = 4'b0100,
        FMS_ST_DONE  = 4'b1000
    } fms_state_e;

    typedef struct packed {
        logic [7:0]  func;
        logic [15:0] addr;
        logic [15:0] count;
        logic [15:0] data;
    } fms_req_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] data;
        logic        broadcast;
    } fms_fan_req_s;
endpackage

// *** src/fms_apb_slave.sv ***
// APB slave front end: decodes a transfer into one-cycle strobes.
// Assumes an APB master on pclk; answers with zero wait states.
`timescale 1ns/1ns
module fms_apb_slave (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] rd_value,
    output logic             pready,
    output logic             pslverr,
    output logic [31:0]      prdata,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic [7:0]       acc_addr,
    output logic [31:0]      acc_wdata,
    input  wire logic        rd_err
);
    logic access;

    always_comb begin
        access    = psel && penable;
        wr_stb    = access && pwrite;
        rd_stb    = access && !pwrite;
        acc_addr  = paddr;
        acc_wdata = pwdata;
        pready    = 1'b1;
        pslverr   = access && rd_err;
        prdata    = rd_stb ? rd_value : 32'h0000_0000;
    end
endmodule // fms_apb_slave

// *** src/fms_timer.sv ***
// Response budget timer; a pulse on expire when the budget runs out.
// Assumes start and stop arrive from logic on pclk.
`timescale 1ns/1ns
module fms_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        start,
    input  wire logic        stop,
    input  wire logic [23:0] limit,
    output logic             expire
);
    logic [23:0] cnt_reg;
    logic [23:0] cnt_next;
    logic        run_reg;
    logic        run_next;
    logic        exp_reg;
    logic        exp_next;

    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        exp_next = 1'b0;
        if (start) begin
            cnt_next = limit;
            run_next = 1'b1;
        end else if (stop) begin
            run_next = 1'b0;
        end else if (run_reg) begin
            if (cnt_reg <= 24'h00_0001) begin
                run_next = 1'b0;
                exp_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 24'h00_0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 24'h00_0000;
            run_reg <= 1'b0;
            exp_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
            exp_reg <= exp_next;
        end
    end

    assign expire = exp_reg;
endmodule // fms_timer

// *** verif/fms_top_assertions.sv ***
// Checker on fms_top ports: APB answer, request timing, fan fields.
// Assumes it is bound into fms_top and sees only that module's ports.
`timescale 1ns/1ns
module fms_top_assertions (
    input logic                  pclk,
    input logic                  presetn,
    input logic                  psel,
    input logic                  penable,
    input logic                  pwrite,
    input logic [7:0]            paddr,
    input logic                  pready,
    input logic                  pslverr,
    input logic [31:0]           prdata,
    input fms_pkg::fms_fan_req_s fan_req,
    input logic                  fan_done,
    input logic                  rsp_valid
);
    logic go_wr;
    logic busy_reg;
    logic busy_next;
    assign go_wr = psel && penable && pwrite && paddr == fms_pkg::A_REQ_GO;
    // A GO while busy is ignored
    assign busy_next = (go_wr && !busy_reg) || (busy_reg && !rsp_valid);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_reg <= 1'h0;
        end else begin
            busy_reg <= busy_next;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_go;
        go_wr && !busy_reg;
    endsequence
    sequence s_answer;
        fan_req.valid || rsp_valid;
    endsequence
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("pready low");
    a_unmapped_err: assert property (psel && penable && paddr >= 8'h64
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_go_answer: assert property (s_go |-> ##[1:4] s_answer)
        else $error("no answer after GO");
    a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
        else $error("rsp_valid too long");
    a_req_pulse: assert property (fan_req.valid |=> !fan_req.valid)
        else $error("fan valid too long");
    a_done_rsp: assert property (fan_done && busy_reg |-> ##[1:3] rsp_valid)
        else $error("no rsp after done");
    a_bcast_fields: assert property (fan_req.valid && fan_req.broadcast |->
        fan_req.write && fan_req.addr <= fms_pkg::HR_ARRAY_RPM)
        else $error("broadcast fields wrong");
    a_fan_window: assert property (fan_req.valid && !fan_req.broadcast |->
        fan_req.addr inside {[fms_pkg::FAN_WIN_FIRST:fms_pkg::FAN_WIN_LAST]})
        else $error("fan addr outside window");
    a_fields_hold: assert property (!fan_req.valid |->
        $stable(fan_req.addr) && $stable(fan_req.data))
        else $error("fan fields moved");
endmodule // fms_top_assertions

bind fms_top fms_top_assertions chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .fan_req(fan_req), .fan_done(fan_done), .rsp_valid(rsp_valid));

// *** verif/fms_fan_model.sv ***
// Behavioural fan-bus engine facing the fan port of fms_top.
// Assumes fan_req on pclk; answers every request after LAT cycles.
`timescale 1ns/1ns
module fms_fan_model #(
    parameter int LAT = 4
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire fms_pkg::fms_fan_req_s fan_req,
    output logic                       fan_done,
    output logic [15:0]                fan_rdata
);
    int          cnt_reg;
    int          cnt_next;
    logic [15:0] rdata_next;
    // Toggle so a stale read cannot match
    always_comb begin
        cnt_next   = cnt_reg > 0 ? cnt_reg - 1 : 0;
        rdata_next = ~fan_rdata;
        if (fan_req.valid) begin
            cnt_next = LAT;
        end
        if (cnt_reg == 1) begin
            rdata_next = fan_req.addr ^ 16'h5A5A;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg   <= 0;
            fan_done  <= 1'h0;
            fan_rdata <= 16'h0000;
        end else begin
            cnt_reg   <= cnt_next;
            fan_done  <= cnt_reg == 1;
            fan_rdata <= rdata_next;
        end
    end
endmodule // fms_fan_model

// *** verif/fms_top_tb.sv ***
// Self-checking bench for fms_top: Modbus requests loaded over APB.
// Assumes fms_fan_model on the fan port and a 10 MHz pclk.
`timescale 1ns/1ns
module fms_top_tb;
    logic        pclk, presetn, psel, penable, pwrite;
    logic        pready, pslverr, fan_done, rsp_valid, err_q;
    logic [7:0]  paddr;
    logic [15:0] fan_rdata;
    logic [31:0] pwdata, prdata, st, rd;
    int          errors, cmp_count;
    fms_pkg::fms_fan_req_s fan_req;

    fms_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .fan_req(fan_req), .fan_done(fan_done), .fan_rdata(fan_rdata),
        .rsp_valid(rsp_valid));
    fms_fan_model fan_u (.pclk(pclk), .presetn(presetn), .fan_req(fan_req),
        .fan_done(fan_done), .fan_rdata(fan_rdata));

    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end

    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        q = prdata;
        err_q = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic mode(input logic [2:0] m);
        apb(1'h1, fms_pkg::A_MODE, {29'h0, m}, st);
    endtask

    task automatic req(input logic [7:0] f, input logic [15:0] a, c, d);
        int n = 0;
        apb(1'h1, fms_pkg::A_REQ_FUNC, {24'h0, f}, st);
        apb(1'h1, fms_pkg::A_REQ_ADDR, {16'h0, a}, st);
        apb(1'h1, fms_pkg::A_REQ_COUNT, {16'h0, c}, st);
        apb(1'h1, fms_pkg::A_REQ_DATA, {16'h0, d}, st);
        apb(1'h1, fms_pkg::A_REQ_GO, 32'h1, st);
        while (rsp_valid !== 1'h1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
        chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
        apb(1'h0, fms_pkg::A_RSP_STATUS, 32'h0, st);
        apb(1'h0, fms_pkg::A_RSP_DATA, 32'h0, rd);
    endtask

    task automatic ex(input logic [7:0] f, input logic [15:0] a, c, d,
                      input logic [7:0] e);
        req(f, a, c, d);
        chk("exception", {24'h0, e}, {24'h0, st[7:0]});
    endtask

    task automatic t_apb;
        apb(1'h0, fms_pkg::A_MODE, 32'h0, rd);
        chk("mode reset", 32'h0, rd);
        apb(1'h0, 8'h24, 32'h0, rd);
        chk("unmapped err", 32'h1, {31'h0, err_q});
        chk("unmapped data", 32'h0, rd);
    endtask

    task automatic t_codes;
        logic [7:0] fc [7] = '{8'h03, 8'h04, 8'h05, 8'h10, 8'h01, 8'h06, 8'h2B};
        mode(3'h1);
        for (int i = 0; i < 7; i++) begin
            ex(fc[i], 16'h3, 16'h1, 16'h1, (i < 4) ? 8'h00 : 8'h01);
        end
    endtask

    task automatic t_limits;
        ex(8'h03, 16'h100, 16'hD, 16'h0, 8'h00);
        ex(8'h03, 16'h100, 16'hE, 16'h0, 8'h03);
        ex(8'h10, 16'h100, 16'hE, 16'h0, 8'h03);
        ex(8'h03, 16'h100, 16'h0, 16'h0, 8'h03);
        ex(8'h04, 16'h200, 16'h9, 16'h0, 8'h00);
        ex(8'h04, 16'hC9F6, 16'hA, 16'h0, 8'h03);
    endtask

    task automatic t_gate;
        for (int m = 0; m < 5; m++) begin
            mode(m[2:0]);
            ex(8'h05, 16'h2, 16'h1, {13'h200, m[2:0]},
               (m inside {[1:3]}) ? 8'h00 : 8'h03);
            req(8'h04, 16'h205, 16'h1, 16'h0);
            chk("fan status", 32'h0, {24'h0, st[7:0]});
            chk("fan data", 32'h585F, {16'h0, rd[15:0]});
        end
        apb(1'h0, fms_pkg::A_SETPOINTS, 32'h0, rd);
        chk("press", 32'h1003, {16'h0, rd[31:16]});
        mode(3'h2);
        ex(8'h05, 16'h3, 16'h1, 16'h0BEE, 8'h00);
        apb(1'h0, fms_pkg::A_SETPOINTS, 32'h0, rd);
        chk("volume", 32'h0BEE, {16'h0, rd[15:0]});
    endtask

    task automatic t_bcast;
        mode(3'h1);
        for (int k = 0; k < 2; k++) begin
            ex(8'h05, {15'h0, k[0]}, 16'h0001, {15'h1500, k[0]}, 8'h00);
            chk("bcast flag", 32'h1, {31'h0, fan_req.broadcast});
            chk("bcast addr", {31'h0, k[0]}, {16'h0, fan_req.addr});
            chk("bcast data", {31'h1500, k[0]}, {16'h0, fan_req.data});
        end
    endtask

    task automatic t_sys;
        mode(3'h1);
        for (int k = 1; k < 7; k++) begin
            apb(1'h1, 8'h3C + 8'(4 * k), 32'h0C00 + 32'(k), st);
            req(8'h04, 16'(k), 16'h0001, 16'h0000);
            chk("sys reg", 32'h0C00 + 32'(k), {16'h0, rd[15:0]});
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_apb;
        t_codes;
        t_limits;
        t_gate;
        t_bcast;
        t_sys;
        print_verdict;
    end

    // Run needs about 800 cycles
    initial begin
        #3_000_000;
        errors++;
        print_verdict;
    end
endmodule // fms_top_tb
